// ==== rtl/lims_mode_select.sv ====
// configuration source selection and mode decode with an apb register port
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module lims_mode_select
    import lims_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic config_source_strap,
    input wire logic rate_select_pin,
    input wire logic media_coding_pin,
    input wire logic host_interface_select_pin,
    input wire logic [1:0] ref_clock_select_pin,
    input wire logic [1:0] tx_timing_mode_pin,
    output logic software_mode,
    output logic line_rate_e4,
    output logic cmi_enable,
    output logic host_parallel,
    output logic [1:0] serial_timing_mode,
    output logic serial_timing_valid,
    output logic [1:0] ref_clock_select,
    output logic [17:0] ref_freq_khz,
    output logic ref_clock_invalid,
    output logic ref_clock_differential
);

    // register decode result, shared by read capture and write strobe
    typedef enum logic [1:0] {
        LIMS_ADDR_NONE,
        LIMS_ADDR_CTRL,
        LIMS_ADDR_STATUS
    } lims_addr_t;

    logic [6:0] mode_ctrl_reg;
    lims_cfg_t pin_cfg;
    lims_cfg_t sw_cfg;
    lims_cfg_t eff_cfg;
    lims_ref_t ref_next;
    lims_cfg_t cfg_reg;
    lims_ref_t ref_reg;
    logic sw_mode_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic setup_phase;
    logic access_phase;
    logic [31:0] status_word;
    lims_addr_t addr_hit;

    // expected reference frequency from rate and clock select together
    function automatic lims_ref_t ref_decode(input logic e4,
                                             input logic [1:0] sel);
        lims_ref_t r;
        r = '{khz: LIMS_FREQ_NONE, invalid: 1'b1, differential: 1'b0};
        if (sel == LIMS_REFSEL_LOW) begin // [RULE_05]
            r.khz = e4 ? LIMS_FREQ_17408 : LIMS_FREQ_19440; // [RULE_04]
            r.invalid = 1'b0;
        end else if (sel == LIMS_REFSEL_MID) begin
            // middle frequency has no counterpart at the e4 rate
            r.khz = e4 ? LIMS_FREQ_NONE : LIMS_FREQ_77760; // [RULE_05]
            r.invalid = e4;
        end else if (sel == LIMS_REFSEL_HIGH) begin
            r.khz = e4 ? LIMS_FREQ_139264 : LIMS_FREQ_155520; // [RULE_04]
            r.invalid = 1'b0;
            r.differential = 1'b1;
        end
        return r;
    endfunction

    // the timing pin has only three levels, so loop timing is software only
    function automatic logic [1:0] pin_timing(input logic [1:0] p);
        logic [1:0] t;
        t = p;
        if (p == LIMS_TIMING_LOOP) begin
            t = LIMS_TIMING_SYNC_CLK;
        end
        return t;
    endfunction

    // one decode keeps read capture and write strobe from drifting apart
    function automatic lims_addr_t addr_decode(input logic [7:0] a);
        lims_addr_t d;
        d = LIMS_ADDR_NONE;
        if (a == LIMS_MODE_CTRL_OFS) begin
            d = LIMS_ADDR_CTRL;
        end else if (a == LIMS_STATUS_OFS) begin
            d = LIMS_ADDR_STATUS;
        end
        return d;
    endfunction

    always_comb begin
        addr_hit = addr_decode(paddr);
    end

    // pins are taken as synchronous, so no resync stage sits here
    always_comb begin
        pin_cfg.rate_e4 = rate_select_pin;
        pin_cfg.media_cmi = media_coding_pin;
        pin_cfg.host_parallel = host_interface_select_pin;
        pin_cfg.refsel = ref_clock_select_pin;
        pin_cfg.timing = pin_timing(tx_timing_mode_pin);
    end

    always_comb begin
        sw_cfg.rate_e4 = mode_ctrl_reg[LIMS_RATE_BIT];
        sw_cfg.media_cmi = mode_ctrl_reg[LIMS_MEDIA_BIT];
        sw_cfg.host_parallel = mode_ctrl_reg[LIMS_HOST_BIT];
        sw_cfg.refsel = mode_ctrl_reg[LIMS_REFSEL_LSB +: 2];
        sw_cfg.timing = mode_ctrl_reg[LIMS_TIMING_LSB +: 2];
    end

    // strap low takes the pins, strap high takes the register bits
    always_comb begin
        if (config_source_strap) begin
            eff_cfg = sw_cfg; // [RULE_02] [RULE_09]
        end else begin
            eff_cfg = pin_cfg; // [RULE_01] [RULE_09]
        end
    end

    always_comb begin
        ref_next = ref_decode(eff_cfg.rate_e4, eff_cfg.refsel); // [RULE_04]
    end

    // one register stage so that all mode outputs change together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= '0;
        end else begin
            cfg_reg <= eff_cfg; // [RULE_09]
        end
    end

    // the mode flag shares the stage so it never leads the settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_mode_reg <= 1'b0;
        end else begin
            sw_mode_reg <= config_source_strap; // [RULE_02]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_reg <= '{khz: LIMS_FREQ_NONE, invalid: 1'b0,
                         differential: 1'b0};
        end else begin
            ref_reg <= ref_next;
        end
    end

    assign software_mode = sw_mode_reg;
    assign line_rate_e4 = cfg_reg.rate_e4; // [RULE_03]
    assign cmi_enable = cfg_reg.media_cmi; // [RULE_06]
    assign host_parallel = cfg_reg.host_parallel; // [RULE_07]
    // timing controls only steer the port while it is serial
    assign serial_timing_valid = !cfg_reg.host_parallel; // [RULE_08]
    assign serial_timing_mode = cfg_reg.timing; // [RULE_08]
    assign ref_clock_select = cfg_reg.refsel;
    assign ref_freq_khz = ref_reg.khz;
    assign ref_clock_invalid = ref_reg.invalid;
    assign ref_clock_differential = ref_reg.differential;

    // apb: read data is captured in setup so the access phase needs no wait
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign pready = access_phase;
    assign prdata = prdata_reg;
    assign pslverr = access_phase && pslverr_reg;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[LIMS_ST_CFG_LSB +: LIMS_CTRL_WIDTH] = cfg_reg;
        status_word[LIMS_ST_SW_BIT] = sw_mode_reg;
        status_word[LIMS_ST_INVALID_BIT] = ref_reg.invalid;
        status_word[LIMS_ST_DIFF_BIT] = ref_reg.differential;
        status_word[LIMS_ST_FREQ_LSB +: 18] = ref_reg.khz;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_phase) begin
            prdata_reg <= 32'h0000_0000;
            if (!pwrite && addr_hit == LIMS_ADDR_CTRL) begin
                prdata_reg <= {25'h0, mode_ctrl_reg};
            end else if (!pwrite && addr_hit == LIMS_ADDR_STATUS) begin
                prdata_reg <= status_word;
            end
        end
    end

    // an unmapped address answers with an error, still with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pslverr_reg <= (addr_hit == LIMS_ADDR_NONE);
        end
    end

    // control bits live in byte lane 0; the register is kept in both modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl_reg <= LIMS_MODE_CTRL_RST;
        end else if (access_phase && pwrite && pstrb[0]
                     && addr_hit == LIMS_ADDR_CTRL) begin
            mode_ctrl_reg <= pwdata[6:0]; // [RULE_02]
        end
    end

endmodule

`default_nettype wire

// ==== rtl/lims_pkg.sv ====
// constants, register map and types for the line interface mode select block
//
// Summary of operation
// (RULE_01) Strap low: hardware mode, settings come from the dedicated control pins.
// (RULE_02) Strap high: control pins ignored, settings come from software register bits.
// (RULE_03) Rate select high or 1 gives 139.264 Mbit/s, low or 0 gives 155.52.
// (RULE_04) Expected reference frequency comes from rate select and clock select together.
// (RULE_05) Clock select 00, 10 and 11 give the low, middle and high reference frequencies.
// (RULE_06) Media coding high or 1 enables CMI coax; low or 0 selects fiber NRZ.
// (RULE_07) Host select configures the framer port as 4-bit parallel or serial.
// (RULE_08) Host select low or 0 gives serial, timed by the transmit timing controls.
// (RULE_09) Every control takes its pin or its bit, following the strap at each change.
package lims_pkg;

    // apb register byte offsets
    localparam logic [7:0] LIMS_MODE_CTRL_OFS = 8'h00;
    localparam logic [7:0] LIMS_STATUS_OFS = 8'h04;

    // mode control field positions
    localparam int LIMS_RATE_BIT = 0;
    localparam int LIMS_MEDIA_BIT = 1;
    localparam int LIMS_HOST_BIT = 2;
    localparam int LIMS_REFSEL_LSB = 3;
    localparam int LIMS_TIMING_LSB = 5;
    localparam int LIMS_CTRL_WIDTH = 7;

    // status field positions
    localparam int LIMS_ST_CFG_LSB = 0;
    localparam int LIMS_ST_SW_BIT = 7;
    localparam int LIMS_ST_INVALID_BIT = 8;
    localparam int LIMS_ST_DIFF_BIT = 9;
    localparam int LIMS_ST_FREQ_LSB = 12;

    localparam logic [6:0] LIMS_MODE_CTRL_RST = 7'h00;

    // clock select encodings
    localparam logic [1:0] LIMS_REFSEL_LOW = 2'h0;
    localparam logic [1:0] LIMS_REFSEL_MID = 2'h2;
    localparam logic [1:0] LIMS_REFSEL_HIGH = 2'h3;

    // serial transmit timing encodings
    localparam logic [1:0] LIMS_TIMING_SYNC_CLK = 2'h0;
    localparam logic [1:0] LIMS_TIMING_PLESIO = 2'h1;
    localparam logic [1:0] LIMS_TIMING_SYNC_DATA = 2'h2;
    localparam logic [1:0] LIMS_TIMING_LOOP = 2'h3;

    // expected reference frequencies in kHz
    localparam logic [17:0] LIMS_FREQ_19440 = 18'h04BF0;
    localparam logic [17:0] LIMS_FREQ_17408 = 18'h04400;
    localparam logic [17:0] LIMS_FREQ_77760 = 18'h12FC0;
    localparam logic [17:0] LIMS_FREQ_155520 = 18'h25F80;
    localparam logic [17:0] LIMS_FREQ_139264 = 18'h22000;
    localparam logic [17:0] LIMS_FREQ_NONE = 18'h00000;

    typedef struct packed {
        logic [1:0] timing;
        logic [1:0] refsel;
        logic host_parallel;
        logic media_cmi;
        logic rate_e4;
    } lims_cfg_t;

    typedef struct packed {
        logic [17:0] khz;
        logic invalid;
        logic differential;
    } lims_ref_t;

endpackage

// ==== sim/lims_board.sv ====
// board model: strap and mode pins, changed just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module lims_board
    import lims_pkg::*;
(
    input wire logic pclk,
    input wire logic want_sw,
    input wire lims_cfg_t want,
    output logic strap,
    output var lims_cfg_t pins
);
    always_ff @(posedge pclk) begin
        strap <= want_sw;
        pins <= want;
    end
endmodule
`default_nettype wire

// ==== sim/lims_mode_select_props.sv ====
// concurrent checks on the mode select ports
`timescale 1ns/1ps
`default_nettype none
module lims_mode_select_props
    import lims_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic config_source_strap,
    input wire logic rate_select_pin,
    input wire logic media_coding_pin,
    input wire logic host_interface_select_pin,
    input wire logic software_mode,
    input wire logic line_rate_e4,
    input wire logic cmi_enable,
    input wire logic host_parallel,
    input wire logic serial_timing_valid,
    input wire logic [1:0] ref_clock_select,
    input wire logic [17:0] ref_freq_khz,
    input wire logic ref_clock_invalid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // guard on past reset: outputs lag the pins by one flop stage
    strap_mode_a: assert property (
        $past(presetn) |-> software_mode == $past(config_source_strap))
        else $error("mode does not follow strap");
    hw_rate_a: assert property ($past(presetn) &&
        !$past(config_source_strap) |-> line_rate_e4 == $past(rate_select_pin))
        else $error("rate not from pin");
    hw_media_a: assert property ($past(presetn) &&
        !$past(config_source_strap) |-> cmi_enable == $past(media_coding_pin))
        else $error("media not from pin");
    hw_host_a: assert property ($past(presetn) &&
        !$past(config_source_strap)
        |-> host_parallel == $past(host_interface_select_pin))
        else $error("host select not from pin");
    serial_valid_a: assert property ($past(presetn) &&
        !$past(config_source_strap)
        |-> serial_timing_valid == !$past(host_interface_select_pin))
        else $error("serial timing valid wrong");
    refsel_invalid_a: assert property (ref_clock_invalid ==
        (ref_clock_select == 2'h1
         || (ref_clock_select == 2'h2 && line_rate_e4)))
        else $error("invalid flag wrong");
    freq_e4_high_a: assert property ($past(presetn) &&
        ref_clock_select == 2'h3 && line_rate_e4
        |-> ref_freq_khz == LIMS_FREQ_139264)
        else $error("e4 high frequency wrong");
    freq_low_a: assert property ($past(presetn) &&
        ref_clock_select == 2'h0 && !line_rate_e4
        |-> ref_freq_khz == LIMS_FREQ_19440)
        else $error("low frequency wrong");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("ready missing in access");
endmodule
bind lims_mode_select lims_mode_select_props chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .config_source_strap(config_source_strap),
    .rate_select_pin(rate_select_pin), .media_coding_pin(media_coding_pin),
    .host_interface_select_pin(host_interface_select_pin),
    .software_mode(software_mode), .line_rate_e4(line_rate_e4),
    .cmi_enable(cmi_enable), .host_parallel(host_parallel),
    .serial_timing_valid(serial_timing_valid),
    .ref_clock_select(ref_clock_select), .ref_freq_khz(ref_freq_khz),
    .ref_clock_invalid(ref_clock_invalid));
`default_nettype wire

// ==== sim/line_interface_mode_select_test.sv ====
// self-checking bench for the mode select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
fail_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module line_interface_mode_select_test
    import lims_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, want_sw = 1'b0, pready, pslverr, err, strap;
    logic [7:0] paddr = 8'h00;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic sw, e4, cmi, parallel, tvalid, inval, diff;
    logic [1:0] tmode, rsel;
    logic [17:0] freq;
    lims_cfg_t want = '0, pins;
    int fail_count = 0, samples_checked = 0;
    always #2 pclk = ~pclk;
    lims_board board (.pclk(pclk), .want_sw(want_sw), .want(want),
        .strap(strap), .pins(pins));
    lims_mode_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_source_strap(strap), .rate_select_pin(pins.rate_e4),
        .media_coding_pin(pins.media_cmi),
        .host_interface_select_pin(pins.host_parallel),
        .ref_clock_select_pin(pins.refsel), .tx_timing_mode_pin(pins.timing),
        .software_mode(sw), .line_rate_e4(e4), .cmi_enable(cmi),
        .host_parallel(parallel), .serial_timing_mode(tmode),
        .serial_timing_valid(tvalid), .ref_clock_select(rsel),
        .ref_freq_khz(freq), .ref_clock_invalid(inval),
        .ref_clock_differential(diff));
    task automatic finish_test();
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] st);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        pstrb <= st;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end else begin
            rdata = prdata;
            err = pslverr;
            {psel, penable} <= 2'b00;
        end
    endtask
    function automatic logic [17:0] efreq(input logic r, input logic [1:0] s);
        case (s)
            2'h0: return r ? LIMS_FREQ_17408 : LIMS_FREQ_19440;
            2'h2: return r ? LIMS_FREQ_NONE : LIMS_FREQ_77760;
            2'h3: return r ? LIMS_FREQ_139264 : LIMS_FREQ_155520;
            default: return LIMS_FREQ_NONE;
        endcase
    endfunction
    task automatic hw_modes_test();
        logic [1:0] s;
        for (int i = 0; i < 8; i++) begin
            s = i[2:1];
            want_sw <= 1'b0;
            want <= {s, s, &s, ~i[0], i[0]};
            settle();
            `CHK("sw", 1'b0, sw)
            `CHK("e4", i[0], e4)
            `CHK("cmi", ~i[0], cmi)
            `CHK("host", &s, parallel)
            `CHK("tvalid", ~&s, tvalid)
            `CHK("inval", s == 2'h1 || s == 2'h2 && i[0], inval)
            `CHK("diff", s == 2'h3, diff)
            `CHK("tmode", (&s) ? 2'h0 : s, tmode)
            `CHK("rsel", s, rsel)
            `CHK("freq", efreq(i[0], s), freq)
        end
    endtask
    task automatic sw_mode_test();
        logic [31:0] st_exp;
        // status: freq at 29:12, sw mode at 7, settings at 6:0
        st_exp = {2'b00, LIMS_FREQ_19440, 5'h01, 7'h60};
        // pins all high so any leak from them shows
        want_sw <= 1'b1;
        want <= 7'h7F;
        apb(1'b1, LIMS_MODE_CTRL_OFS, 32'h60, 4'hF);
        settle();
        `CHK("sw", 1'b1, sw)
        `CHK("e4", 1'b0, e4)
        `CHK("cmi", 1'b0, cmi)
        `CHK("host", 1'b0, parallel)
        `CHK("tmode", LIMS_TIMING_LOOP, tmode)
        `CHK("freq", LIMS_FREQ_19440, freq)
        apb(1'b0, LIMS_MODE_CTRL_OFS, 32'h0, 4'hF);
        `CHK("ctrl", 32'h60, rdata)
        apb(1'b0, LIMS_STATUS_OFS, 32'h0, 4'hF);
        `CHK("status", st_exp, rdata)
        `CHK("status err", 1'b0, err)
        apb(1'b0, 8'h08, 32'h0, 4'hF);
        `CHK("unmapped", 1'b1, err)
    endtask
    task automatic switch_test();
        want_sw <= 1'b0;
        settle();
        `CHK("e4", 1'b1, e4)
        `CHK("cmi", 1'b1, cmi)
        `CHK("freq", LIMS_FREQ_139264, freq)
        // register stays writable in hardware mode; lane 0 off is ignored
        apb(1'b1, LIMS_MODE_CTRL_OFS, 32'h01, 4'hF);
        apb(1'b1, LIMS_MODE_CTRL_OFS, 32'h7E, 4'h0);
        apb(1'b0, LIMS_MODE_CTRL_OFS, 32'h0, 4'hF);
        `CHK("ctrl", 32'h01, rdata)
        settle();
        `CHK("e4", 1'b1, e4)
        `CHK("cmi", 1'b1, cmi)
        want_sw <= 1'b1;
        settle();
        `CHK("e4", 1'b1, e4)
        `CHK("cmi", 1'b0, cmi)
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        hw_modes_test();
        sw_mode_test();
        switch_test();
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
